// File: bench/test_mcr_config_regs.sv
`timescale 1ns/10ps
module test_mcr_config_regs;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [5:0] cfg_addr = 6'h00;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_wdata = 8'h00;
  logic [1:0] length_config = 2'h1;
  logic [7:0] channel_number = 8'h00;
  logic [7:0] cfg_rdata;
  logic [2:0] modulation_select;
  logic mod_valid, manchester_active, fixed_length_mode, preamble_enable, error_correction_enable;
  logic [4:0] preamble_bytes;
  logic [1:0] sync_word_count;
  logic [19:0] channel_offset;
  logic [10:0] deviation_step;
  logic [2:0] msk_phase_fraction;
  logic [7:0] rv;
  int mismatches = 0;
  int n_compared = 0;
  logic [4:0] pre_tab [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h18};
  logic [7:0] mask_tab [4] = '{8'h77, 8'hF3, 8'hFF, 8'h77};

  mcr_config_regs dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .length_config(length_config),
    .channel_number(channel_number), .modulation_select(modulation_select), .mod_valid(mod_valid),
    .manchester_active(manchester_active), .fixed_length_mode(fixed_length_mode),
    .preamble_enable(preamble_enable), .preamble_bytes(preamble_bytes), .sync_word_count(sync_word_count),
    .error_correction_enable(error_correction_enable), .channel_offset(channel_offset),
    .deviation_step(deviation_step), .msk_phase_fraction(msk_phase_fraction));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    cfg_wr = 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    cfg_rd = 1'b0;
    d = cfg_rdata;
  endtask

  // Derived outputs lag the register by one edge
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic finish_test;
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    settle();
    chk(modulation_select, 20'h1);
    chk(sync_word_count, 20'h1);
    chk(preamble_bytes, 20'h4);
    chk(error_correction_enable, 20'h0);
    chk(deviation_step, 20'hF0);
    rd(mcr_pkg::ADDR_MOD_SYNC, rv);
    chk(rv, 20'h12);
    rd(mcr_pkg::ADDR_FEC_PRE, rv);
    chk(rv, 20'h22);
    rd(mcr_pkg::ADDR_SPC_MANT, rv);
    chk(rv, 20'hF8);
    rd(mcr_pkg::ADDR_DEVIATION, rv);
    chk(rv, 20'h47);
    wr(mcr_pkg::ADDR_DEVIATION, 8'h35);
    for (int m = 0; m < 8; m++) begin
      wr(mcr_pkg::ADDR_MOD_SYNC, {1'b0, 3'(m), 4'h2});
      settle();
      chk(modulation_select, 20'(m));
      chk(mod_valid, 20'(m == 0 || m == 1 || m == 3 || m == 7));
      chk(deviation_step, (m <= 1) ? 20'd104 : 20'd0);
      chk(msk_phase_fraction, (m == 7) ? 20'h5 : 20'h0);
    end
    for (int s = 0; s < 8; s++) begin
      wr(mcr_pkg::ADDR_MOD_SYNC, {5'h02, 3'(s)});
      settle();
      chk(preamble_enable, 20'(s[1:0] != 2'b00));
      chk(sync_word_count, (s[1:0] == 2'b00) ? 20'h0 : (s[1:0] == 2'b11) ? 20'h2 : 20'h1);
    end
    for (int p = 0; p < 8; p++) begin
      wr(mcr_pkg::ADDR_FEC_PRE, {p[0], 3'(p), 4'h2});
      settle();
      chk(preamble_bytes, 20'(pre_tab[p]));
      chk(error_correction_enable, 20'(p[0]));
    end
    for (int i = 0; i < 4; i++) begin
      wr(6'(6'h12 + i), (i == 0) ? 8'hF7 : 8'hFF);
      rd(6'(6'h12 + i), rv);
      chk(rv, 20'(mask_tab[i]));
    end
    wr(6'h16, 8'hFF);
    rd(6'h16, rv);
    chk(rv, 20'h0);
    clk_en = 1'b0;
    wr(mcr_pkg::ADDR_SPC_MANT, 8'h00);
    clk_en = 1'b1;
    rd(mcr_pkg::ADDR_SPC_MANT, rv);
    chk(rv, 20'hFF);
    wr(mcr_pkg::ADDR_FEC_PRE, 8'h23);
    channel_number = 8'hFF;
    settle();
    chk(channel_offset, 20'hFE808);
    length_config = 2'h0;
    wr(mcr_pkg::ADDR_MOD_SYNC, 8'h1A);
    settle();
    chk(manchester_active, 20'h1);
    chk(fixed_length_mode, 20'h1);
    length_config = 2'h1;
    settle();
    chk(manchester_active, 20'h0);
    chk(fixed_length_mode, 20'h0);
    finish_test();
  end
endmodule

// File: rtl/mcr_config_regs.sv
`timescale 1ns/10ps
// Functional notes
// - Modulation selector 000 is two-level FSK, 001 GFSK (reset), 011 OOK, 111 MSK, others unassigned.
// - Manchester bit enables Manchester coding, which only takes effect in fixed packet length mode.
// - Sync mode 000 or 100 sends neither preamble nor sync word.
// - Sync mode 001, 010, 101 or 110 sends one 16-bit sync word after the preamble; reset is 010.
// - Sync mode 011 or 111 sends the sync word twice after the preamble.
// - Error-correction enable applies FEC with interleaving to the payload; clear at reset.
// - Preamble codes 0..7 give at least 2, 3, 4, 6, 8, 12, 16, 24 bytes; reset code gives 4.
// - Channel offset is (256 + spacing mantissa) shifted by spacing exponent times channel number, in xtal/2^18.
// - For FSK and GFSK the deviation is (8 + mantissa) shifted by exponent, in xtal/2^17.
// - Under MSK the deviation mantissa is the phase-change fraction of a symbol, not a deviation.
// - Fixed packet length mode is length code 00, with payload length from a separate register.
module mcr_config_regs (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [5:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic [1:0] length_config,
  input wire logic [7:0] channel_number,
  output logic [2:0] modulation_select,
  output logic mod_valid,
  output logic manchester_active,
  output logic fixed_length_mode,
  output logic preamble_enable,
  output logic [4:0] preamble_bytes,
  output logic [1:0] sync_word_count,
  output logic error_correction_enable,
  output logic [19:0] channel_offset,
  output logic [10:0] deviation_step,
  output logic [2:0] msk_phase_fraction
);
  logic [7:0] mod_sync;
  logic [7:0] fec_pre;
  logic [7:0] spc_mant;
  logic [7:0] deviation;

  function automatic logic [4:0] pre_bytes(input logic [2:0] code);
    case (code)
      3'h0: pre_bytes = 5'h02;
      3'h1: pre_bytes = 5'h03;
      3'h2: pre_bytes = 5'h04;
      3'h3: pre_bytes = 5'h06;
      3'h4: pre_bytes = 5'h08;
      3'h5: pre_bytes = 5'h0C;
      3'h6: pre_bytes = 5'h10;
      default: pre_bytes = 5'h18;
    endcase
  endfunction

  wire [2:0] mod_fld = mod_sync[mcr_pkg::MOD_SEL_LSB +: 3];
  wire [2:0] sync_fld = mod_sync[mcr_pkg::SYNC_LSB +: 3];
  wire [1:0] spc_exp = fec_pre[mcr_pkg::SPC_EXP_LSB +: 2];
  wire [2:0] dev_exp = deviation[mcr_pkg::DEV_EXP_LSB +: 3];
  wire [2:0] dev_mant = deviation[mcr_pkg::DEV_MANT_LSB +: 3];
  wire wr_mod = cfg_wr && cfg_addr == mcr_pkg::ADDR_MOD_SYNC;
  wire wr_fec = cfg_wr && cfg_addr == mcr_pkg::ADDR_FEC_PRE;
  wire wr_spc = cfg_wr && cfg_addr == mcr_pkg::ADDR_SPC_MANT;
  wire wr_dev = cfg_wr && cfg_addr == mcr_pkg::ADDR_DEVIATION;

  // Unassigned codes leave the modulator without a valid format
  wire next_mod_valid = mod_fld == mcr_pkg::MCR_MOD_FSK2 || mod_fld == mcr_pkg::MCR_MOD_GFSK ||
    mod_fld == mcr_pkg::MCR_MOD_OOK || mod_fld == mcr_pkg::MCR_MOD_MSK;
  wire is_fsk = mod_fld == mcr_pkg::MCR_MOD_FSK2 || mod_fld == mcr_pkg::MCR_MOD_GFSK;
  wire is_msk = mod_fld == mcr_pkg::MCR_MOD_MSK;
  wire next_fixed = length_config == mcr_pkg::LEN_FIXED;
  // Gate rather than refuse the write so a later mode change still takes effect
  wire next_manch = mod_sync[mcr_pkg::MANCH_BIT] && next_fixed;
  wire next_pre_en = sync_fld[1:0] != 2'b00;
  wire [1:0] next_sync_cnt = (sync_fld[1:0] == 2'b00) ? 2'h0 :
    (sync_fld[1:0] == 2'b11) ? 2'h2 : 2'h1;
  wire [11:0] spc_scaled = {3'h0, mcr_pkg::SPC_HIDDEN_ONE + {1'b0, spc_mant}} << spc_exp;
  // Widen both factors first so the product is never formed at 12 bits
  wire [19:0] next_channel_number_off = 20'(spc_scaled) * 20'(channel_number);
  wire [10:0] dev_scaled = {7'h00, mcr_pkg::DEV_HIDDEN_ONE + {1'b0, dev_mant}} << dev_exp;
  wire [10:0] next_dev = is_fsk ? dev_scaled : 11'h000;
  wire [2:0] next_msk = is_msk ? dev_mant : 3'h0;
  wire [7:0] next_rdata = (cfg_addr == mcr_pkg::ADDR_MOD_SYNC) ? mod_sync :
    (cfg_addr == mcr_pkg::ADDR_FEC_PRE) ? fec_pre :
    (cfg_addr == mcr_pkg::ADDR_SPC_MANT) ? spc_mant :
    (cfg_addr == mcr_pkg::ADDR_DEVIATION) ? deviation : 8'h00;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mod_sync <= mcr_pkg::RST_MOD_SYNC;
      fec_pre <= mcr_pkg::RST_FEC_PRE;
      spc_mant <= mcr_pkg::RST_SPC_MANT;
      deviation <= mcr_pkg::RST_DEVIATION;
      cfg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (wr_mod) mod_sync <= cfg_wdata & mcr_pkg::MASK_MOD_SYNC;
      if (wr_fec) fec_pre <= cfg_wdata & mcr_pkg::MASK_FEC_PRE;
      if (wr_spc) spc_mant <= cfg_wdata & mcr_pkg::MASK_SPC_MANT;
      if (wr_dev) deviation <= cfg_wdata & mcr_pkg::MASK_DEVIATION;
      if (cfg_rd) cfg_rdata <= next_rdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      modulation_select <= 3'h0;
      mod_valid <= 1'b0;
      manchester_active <= 1'b0;
      fixed_length_mode <= 1'b0;
      preamble_enable <= 1'b0;
      preamble_bytes <= 5'h00;
      sync_word_count <= 2'h0;
      error_correction_enable <= 1'b0;
      channel_offset <= 20'h00000;
      deviation_step <= 11'h000;
      msk_phase_fraction <= 3'h0;
    end else if (clk_en) begin
      modulation_select <= mod_fld;
      mod_valid <= next_mod_valid;
      manchester_active <= next_manch;
      fixed_length_mode <= next_fixed;
      preamble_enable <= next_pre_en;
      preamble_bytes <= pre_bytes(fec_pre[mcr_pkg::PRE_LSB +: 3]);
      sync_word_count <= next_sync_cnt;
      error_correction_enable <= fec_pre[mcr_pkg::FEC_BIT];
      channel_offset <= next_channel_number_off;
      deviation_step <= next_dev;
      msk_phase_fraction <= next_msk;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_mod_valid;
    clk_en |=> mod_valid == ($past(mod_fld) inside {3'b000, 3'b001, 3'b011, 3'b111});
  endproperty
  a_mod_valid: assert property (p_mod_valid) else $error("modulation validity wrong");

  property p_manch;
    clk_en |=> manchester_active == ($past(mod_sync[3]) && $past(length_config) == 2'b00);
  endproperty
  a_manch: assert property (p_manch) else $error("manchester gating wrong");

  property p_no_sync;
    clk_en && sync_fld[1:0] == 2'b00 |=> !preamble_enable && sync_word_count == 2'h0;
  endproperty
  a_no_sync: assert property (p_no_sync) else $error("preamble or sync sent when disabled");

  property p_one_sync;
    clk_en && (sync_fld[1:0] == 2'b01 || sync_fld[1:0] == 2'b10) |=> preamble_enable && sync_word_count == 2'h1;
  endproperty
  a_one_sync: assert property (p_one_sync) else $error("single sync word expected");

  property p_two_sync;
    clk_en && sync_fld[1:0] == 2'b11 |=> preamble_enable && sync_word_count == 2'h2;
  endproperty
  a_two_sync: assert property (p_two_sync) else $error("repeated sync word expected");

  property p_fec;
    clk_en |=> error_correction_enable == $past(fec_pre[7]);
  endproperty
  a_fec: assert property (p_fec) else $error("fec enable mismatch");

  property p_pre_max;
    clk_en && fec_pre[6:4] == 3'h7 |=> preamble_bytes == 5'd24;
  endproperty
  a_pre_max: assert property (p_pre_max) else $error("preamble count for code 7 wrong");

  property p_pre_min;
    clk_en |=> preamble_bytes >= 5'd2;
  endproperty
  a_pre_min: assert property (p_pre_min) else $error("preamble below two bytes");

  property p_channel_number;
    clk_en |=> channel_offset == 20'(((20'd256 + $past(spc_mant)) << $past(spc_exp)) * $past(channel_number));
  endproperty
  a_channel_number: assert property (p_channel_number) else $error("channel offset wrong");

  property p_dev;
    clk_en && is_fsk |=> deviation_step == 11'(((11'd8 + $past(dev_mant)) << $past(dev_exp)));
  endproperty
  a_dev: assert property (p_dev) else $error("deviation wrong");

  property p_msk;
    clk_en && is_msk |=> msk_phase_fraction == $past(dev_mant) && deviation_step == 11'h000;
  endproperty
  a_msk: assert property (p_msk) else $error("msk reinterpretation wrong");

  property p_reserved;
    cfg_rd && clk_en && cfg_addr == 6'h15 |=> cfg_rdata[7] == 1'b0 && cfg_rdata[3] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_mod_reserved;
    cfg_rd && clk_en && cfg_addr == mcr_pkg::ADDR_MOD_SYNC |=> cfg_rdata[7] == 1'b0;
  endproperty
  a_mod_reserved: assert property (p_mod_reserved) else $error("modulation reserved bit not zero");

  property p_fec_reserved;
    cfg_rd && clk_en && cfg_addr == mcr_pkg::ADDR_FEC_PRE |=> cfg_rdata[3:2] == 2'b00;
  endproperty
  a_fec_reserved: assert property (p_fec_reserved) else $error("preamble reserved bits not zero");

  property p_unmapped_rd;
    cfg_rd && clk_en && !(cfg_addr inside {6'h12, 6'h13, 6'h14, 6'h15}) |=> cfg_rdata == 8'h00;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

  property p_fixed;
    clk_en |=> fixed_length_mode == ($past(length_config) == 2'b00);
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed length mode wrong");

  property p_ook;
    clk_en && mod_fld == 3'b011 |=> deviation_step == 11'h000 && msk_phase_fraction == 3'h0;
  endproperty
  a_ook: assert property (p_ook) else $error("deviation given under on-off keying");

  property p_spc_write;
    clk_en && wr_spc |=> spc_mant == $past(cfg_wdata);
  endproperty
  a_spc_write: assert property (p_spc_write) else $error("spacing mantissa write lost");

  c_msk: cover property (clk_en && is_msk);
  c_two_sync: cover property (clk_en && sync_fld[1:0] == 2'b11);
  c_manch: cover property (manchester_active);
  c_write_read: cover property (wr_dev && clk_en ##1 cfg_rd && clk_en);
endmodule

// File: rtl/mcr_pkg.sv
package mcr_pkg;
  localparam logic [5:0] ADDR_MOD_SYNC = 6'h12;
  localparam logic [5:0] ADDR_FEC_PRE = 6'h13;
  localparam logic [5:0] ADDR_SPC_MANT = 6'h14;
  localparam logic [5:0] ADDR_DEVIATION = 6'h15;

  localparam logic [7:0] RST_MOD_SYNC = 8'h12;
  localparam logic [7:0] RST_FEC_PRE = 8'h22;
  localparam logic [7:0] RST_SPC_MANT = 8'hF8;
  localparam logic [7:0] RST_DEVIATION = 8'h47;

  localparam logic [7:0] MASK_MOD_SYNC = 8'h7F;
  localparam logic [7:0] MASK_FEC_PRE = 8'hF3;
  localparam logic [7:0] MASK_SPC_MANT = 8'hFF;
  localparam logic [7:0] MASK_DEVIATION = 8'h77;

  localparam int MOD_SEL_LSB = 4;
  localparam int MANCH_BIT = 3;
  localparam int SYNC_LSB = 0;
  localparam int FEC_BIT = 7;
  localparam int PRE_LSB = 4;
  localparam int SPC_EXP_LSB = 0;
  localparam int DEV_EXP_LSB = 4;
  localparam int DEV_MANT_LSB = 0;

  localparam logic [8:0] SPC_HIDDEN_ONE = 9'h100;
  localparam logic [3:0] DEV_HIDDEN_ONE = 4'h8;
  localparam logic [1:0] LEN_FIXED = 2'h0;

  typedef enum logic [2:0] {
    MCR_MOD_FSK2 = 3'b000,
    MCR_MOD_GFSK = 3'b001,
    MCR_MOD_OOK = 3'b011,
    MCR_MOD_MSK = 3'b111
  } mcr_mod_e;
endpackage
